// ===== inc/twm_pkg.sv
// constants and types for the two-wire master send block
// assumes a 10 MHz system clock and open-drain bus pins outside
package twm_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int SCL_PERIOD_NS = 800;
	// quarter of a bus bit, rounded down, at least one cycle
	localparam int QTR_RAW = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam logic [3:0] QTR_LAST = 4'((QTR_RAW < 1) ? 0 : QTR_RAW - 1);

	// ----------------------------------------
	// bit phases and counts
	// ----------------------------------------
	localparam logic [1:0] PH_SETUP  = 2'h0;
	localparam logic [1:0] PH_RISE   = 2'h1;
	localparam logic [1:0] PH_SAMPLE = 2'h2;
	localparam logic [1:0] PH_FALL   = 2'h3;
	localparam logic [2:0] BIT_MSB   = 3'h7;
	localparam logic [2:0] BIT_LSB   = 3'h0;
	localparam int         RW_POS    = 0;
	localparam int         EVT_DEPTH = 8;
	localparam int         CODE_W    = 8;

	// ----------------------------------------
	// status codes, low two bits are the prescaler field
	// ----------------------------------------
	localparam logic [7:0] CODE_START     = 8'h08;
	localparam logic [7:0] CODE_REP_START = 8'h10;
	localparam logic [7:0] CODE_SLAW_ACK  = 8'h18;
	localparam logic [7:0] CODE_SLAW_NACK = 8'h20;
	localparam logic [7:0] CODE_DATA_ACK  = 8'h28;
	localparam logic [7:0] CODE_DATA_NACK = 8'h30;
	localparam logic [7:0] CODE_ARB_LOST  = 8'h38;
	localparam logic [7:0] CODE_SLAR_ACK  = 8'h40;
	localparam logic [7:0] CODE_SLAR_NACK = 8'h48;
	localparam logic [7:0] CODE_NONE      = 8'hf8;
	localparam logic [7:0] CODE_MASK      = 8'hf8;
	localparam logic [7:0] DATA_RESET     = 8'h00;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE      = 4'h0,
		ST_WAIT_FREE = 4'h1,
		ST_START     = 4'h2,
		ST_BIT       = 4'h3,
		ST_ACK       = 4'h4,
		ST_STOP      = 4'h5,
		ST_REPORT    = 4'h6,
		ST_HOLD      = 4'h7
	} twm_state_t;

	// one software write to the control register
	typedef struct packed {
		logic enable;
		logic start_request;
		logic stop_request;
		logic flag_clr;
	} twm_ctl_t;

endpackage

// ===== design/twm_master_tx.sv
// two-wire master send engine with its status event buffer
// assumes software drives the control/data strobes on clk_i; bus pins are open drain
// How it works
// - start waits for a free bus, then sets the flag with code 08.
// - address direction bit picks send or receive master mode.
// - after write address and acknowledge, flag set with 18, 20 or 38; read address gives 40 or 48.
// - status codes carry zero prescaler bits; software masks them anyway.
// - data write while flag low is dropped and sets the collision flag.
// - after placing stop on the bus the stop request clears itself.
// - repeated start uses the start value, reports 10, keeps the bus.
// - address with read bit after 10 switches to receive mode.
// - on clear after 18..30, start/stop bits choose byte, restart, stop, stop+start.
// - after a data byte the flag sets with 28 on ack, 30 on nack.
// - lost arbitration releases the bus and reports 38; clear idles or restarts when free.
// - writing one clears the completion flag, writing zero keeps it.
// - while the flag is set the bus transfer stays frozen.
`timescale 1ns/1ps

// ----------------------------------------
// event buffer
// ----------------------------------------
module twm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic             full;
	logic             empty;

	assign empty       = (wr_ptr == rd_ptr);
	assign full        = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign in_ready_o  = !full;
	assign out_valid_o = !empty;
	assign out_data_o  = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge clk_i) begin
		if (in_valid_i && !full) begin
			mem[wr_ptr[AW-1:0]] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (in_valid_i && !full) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (out_ready_i && !empty) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule // twm_fifo

// ----------------------------------------
// master send engine
// ----------------------------------------
module twm_master_tx
	import twm_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              ctl_wr_i,
	input  wire twm_ctl_t          ctl_i,
	input  wire logic              data_wr_i,
	input  wire logic [7:0]        data_i,
	output logic                   flag_o,
	output logic                   write_collision_flag_o,
	output logic                   start_request_o,
	output logic                   stop_request_o,
	output logic                   enable_o,
	output logic [7:0]             bus_state_reg_o,
	output logic [7:0]             shift_data_reg_o,
	output logic                   master_receive_mode_o,
	output logic                   bus_busy_o,
	output logic                   evt_valid_o,
	input  wire logic              evt_ready_i,
	output logic [CODE_W-1:0]      evt_code_o,
	input  wire logic              scl_i,
	output logic                   scl_o,
	output logic                   scl_oe_o,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe_o
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	twm_state_t  state;
	logic        flag;
	logic        start_request;
	logic        stop_request;
	logic        enable;
	logic        write_collision_flag;
	logic [7:0]  shift_data_reg;
	logic [7:0]  bus_state_reg;
	logic [7:0]  shifter;
	logic [7:0]  pend_code;
	logic [2:0]  bit_cnt;
	logic [3:0]  qcnt;
	logic [1:0]  ph;
	logic        scl_m, scl_s, scl_p;
	logic        sda_m, sda_s, sda_p;
	logic        bus_busy;
	logic        owned;
	logic        lost;
	logic        is_addr;
	logic        addr_rw;
	logic        need_addr;
	logic        master_receive_mode;
	logic        scl_oe;
	logic        sda_oe;
	logic        timed;
	logic        adv;
	logic        set_flag;
	logic        stop_done;
	logic        fifo_in_ready;

	function automatic logic at_phase(input logic a, input logic [1:0] p, input logic [1:0] q);
		return a && (p == q);
	endfunction

	// ----------------------------------------
	// pin synchronisers and bus watch
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_p <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_m <= scl_i;
			scl_s <= scl_m;
			scl_p <= scl_s;
			sda_m <= sda_i;
			sda_s <= sda_m;
			sda_p <= sda_s;
		end
	end

	// start/stop seen from any master, ours included
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_busy <= 1'b0;
		end else if (scl_s && scl_p && sda_p && !sda_s) begin
			bus_busy <= 1'b1;
		end else if (scl_s && scl_p && !sda_p && sda_s) begin
			bus_busy <= 1'b0;
		end
	end

	// ----------------------------------------
	// quarter-bit timing
	// ----------------------------------------
	assign timed = (state == ST_START) || (state == ST_BIT) ||
		(state == ST_ACK) || (state == ST_STOP);
	// a slave stretching the clock holds us in the sample phase
	assign adv = timed && (qcnt == QTR_LAST) && !((ph == PH_SAMPLE) && !scl_s);

	always_ff @(posedge clk_i) begin
		if (rst_i || !timed || lost) begin
			qcnt <= '0;
			ph   <= PH_SETUP;
		end else if (adv) begin
			qcnt <= '0;
			ph   <= ph + 2'h1;
		end else if (qcnt != QTR_LAST) begin
			qcnt <= qcnt + 4'h1;
		end
	end

	// ----------------------------------------
	// software side: control, data, flags
	// ----------------------------------------
	assign set_flag  = (state == ST_REPORT) && fifo_in_ready;
	assign stop_done = (state == ST_STOP) && at_phase(adv, ph, PH_FALL);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enable        <= 1'b0;
			start_request <= 1'b0;
			stop_request  <= 1'b0;
		end else if (ctl_wr_i) begin
			enable        <= ctl_i.enable;
			start_request <= ctl_i.start_request;
			stop_request  <= ctl_i.stop_request;
		end else if (stop_done) begin
			stop_request <= 1'b0;
		end
	end

	// set beats a clear landing in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag <= 1'b0;
		end else if (set_flag) begin
			flag <= 1'b1;
		end else if (ctl_wr_i && ctl_i.flag_clr) begin
			flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shift_data_reg       <= DATA_RESET;
			write_collision_flag <= 1'b0;
		end else if (data_wr_i && flag) begin
			shift_data_reg       <= data_i;
			write_collision_flag <= 1'b0;
		end else if (data_wr_i) begin
			write_collision_flag <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_state_reg <= CODE_NONE;
		end else if (set_flag) begin
			bus_state_reg <= pend_code & CODE_MASK;
		end else if (ctl_wr_i && ctl_i.flag_clr) begin
			bus_state_reg <= CODE_NONE;
		end
	end

	// ----------------------------------------
	// bus sequencer
	// ----------------------------------------
	// status reads f8 once the flag is cleared, so the last pushed code decides
	assign need_addr = (pend_code == CODE_START) || (pend_code == CODE_REP_START);

	always_ff @(posedge clk_i) begin
		if (rst_i || !enable) begin
			state               <= ST_IDLE;
			scl_oe              <= 1'b0;
			sda_oe              <= 1'b0;
			owned               <= 1'b0;
			lost                <= 1'b0;
			is_addr             <= 1'b0;
			addr_rw             <= 1'b0;
			master_receive_mode <= 1'b0;
			shifter             <= DATA_RESET;
			pend_code           <= CODE_NONE;
			bit_cnt             <= BIT_MSB;
		end else begin
			case (state)
			ST_IDLE: begin
				if (start_request && !flag) begin
					state <= ST_WAIT_FREE;
				end
			end
			ST_WAIT_FREE: begin
				if (!bus_busy) begin
					state <= ST_START;
				end
			end
			ST_START: begin
				if (at_phase(adv, ph, PH_SETUP)) begin
					sda_oe <= 1'b0;
				end else if (at_phase(adv, ph, PH_RISE)) begin
					scl_oe <= 1'b0;
				end else if (at_phase(adv, ph, PH_SAMPLE)) begin
					sda_oe <= 1'b1;
				end else if (at_phase(adv, ph, PH_FALL)) begin
					scl_oe    <= 1'b1;
					pend_code <= owned ? CODE_REP_START : CODE_START;
					owned     <= 1'b1;
					state     <= ST_REPORT;
				end
			end
			ST_BIT: begin
				if (at_phase(adv, ph, PH_SETUP)) begin
					sda_oe <= !shifter[7];
				end else if (at_phase(adv, ph, PH_RISE)) begin
					scl_oe <= 1'b0;
				end else if (at_phase(adv, ph, PH_SAMPLE) && shifter[7] && !sda_s) begin
					// another master pulled a one low: give up the bus
					sda_oe    <= 1'b0;
					lost      <= 1'b1;
					owned     <= 1'b0;
					pend_code <= CODE_ARB_LOST;
					state     <= ST_REPORT;
				end else if (at_phase(adv, ph, PH_FALL)) begin
					scl_oe  <= 1'b1;
					shifter <= {shifter[6:0], 1'b0};
					if (bit_cnt == BIT_LSB) begin
						state <= ST_ACK;
					end else begin
						bit_cnt <= bit_cnt - 3'h1;
					end
				end
			end
			ST_ACK: begin
				if (at_phase(adv, ph, PH_SETUP)) begin
					sda_oe <= 1'b0;
				end else if (at_phase(adv, ph, PH_RISE)) begin
					scl_oe <= 1'b0;
				end else if (at_phase(adv, ph, PH_SAMPLE)) begin
					if (!is_addr) begin
						pend_code <= sda_s ? CODE_DATA_NACK : CODE_DATA_ACK;
					end else if (addr_rw) begin
						pend_code           <= sda_s ? CODE_SLAR_NACK : CODE_SLAR_ACK;
						master_receive_mode <= 1'b1;
					end else begin
						pend_code           <= sda_s ? CODE_SLAW_NACK : CODE_SLAW_ACK;
						master_receive_mode <= 1'b0;
					end
				end else if (at_phase(adv, ph, PH_FALL)) begin
					scl_oe <= 1'b1;
					state  <= ST_REPORT;
				end
			end
			ST_STOP: begin
				if (at_phase(adv, ph, PH_SETUP)) begin
					sda_oe <= 1'b1;
				end else if (at_phase(adv, ph, PH_RISE)) begin
					scl_oe <= 1'b0;
				end else if (at_phase(adv, ph, PH_SAMPLE)) begin
					sda_oe <= 1'b0;
				end else if (at_phase(adv, ph, PH_FALL)) begin
					owned               <= 1'b0;
					master_receive_mode <= 1'b0;
					state               <= start_request ? ST_WAIT_FREE : ST_IDLE;
				end
			end
			ST_REPORT: begin
				// a full event buffer stalls the flag and the bus
				if (fifo_in_ready) begin
					state <= ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (!flag) begin
					if (lost) begin
						lost  <= 1'b0;
						state <= start_request ? ST_WAIT_FREE : ST_IDLE;
					end else if (stop_request) begin
						state <= ST_STOP;
					end else if (start_request) begin
						state <= ST_START;
					end else if (need_addr) begin
						shifter <= shift_data_reg;
						addr_rw <= shift_data_reg[RW_POS];
						is_addr <= 1'b1;
						bit_cnt <= BIT_MSB;
						state   <= ST_BIT;
					end else begin
						shifter <= shift_data_reg;
						is_addr <= 1'b0;
						bit_cnt <= BIT_MSB;
						state   <= ST_BIT;
					end
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	// ----------------------------------------
	// event buffer and outputs
	// ----------------------------------------
	twm_fifo #(
		.WIDTH (CODE_W),
		.DEPTH (EVT_DEPTH)
	) u_evt (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (set_flag),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (pend_code & CODE_MASK),
		.out_valid_o (evt_valid_o),
		.out_ready_i (evt_ready_i),
		.out_data_o  (evt_code_o)
	);

	assign flag_o                 = flag;
	assign write_collision_flag_o = write_collision_flag;
	assign start_request_o        = start_request;
	assign stop_request_o         = stop_request;
	assign enable_o               = enable;
	assign bus_state_reg_o        = bus_state_reg;
	assign shift_data_reg_o       = shift_data_reg;
	assign master_receive_mode_o  = master_receive_mode;
	assign bus_busy_o             = bus_busy;
	assign scl_o                  = 1'b0;
	assign sda_o                  = 1'b0;
	assign scl_oe_o               = scl_oe;
	assign sda_oe_o               = sda_oe;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence seq_stop_end;
		(state == ST_STOP) && adv && (ph == PH_FALL);
	endsequence
	sequence seq_addr_ack;
		(state == ST_ACK) && adv && (ph == PH_SAMPLE) && is_addr && !addr_rw && !sda_s;
	endsequence

	a_wcol_set: assert property (data_wr_i && !flag |=> write_collision_flag)
		else $error("collision flag not set");
	a_wcol_keep: assert property (data_wr_i && !flag |=> $stable(shift_data_reg))
		else $error("data changed on collision");
	a_flag_clear: assert property (ctl_wr_i && ctl_i.flag_clr && !set_flag |=> !flag)
		else $error("flag not cleared by one");
	a_flag_keep: assert property (flag && ctl_wr_i && !ctl_i.flag_clr |=> flag)
		else $error("flag cleared by zero");
	a_suspend_hold: assert property (flag && enable |-> state == ST_HOLD && $stable(scl_oe))
		else $error("bus moved while flag set");
	a_stop_clear: assert property (seq_stop_end |=> !stop_request || $past(ctl_wr_i))
		else $error("stop request not cleared");
	a_start_wait: assert property (state == ST_WAIT_FREE && bus_busy && enable
		|=> state == ST_WAIT_FREE)
		else $error("start on busy bus");
	a_start_code: assert property ((state == ST_START) && adv && (ph == PH_FALL) && !owned
		|=> pend_code == CODE_START ##1 (state == ST_REPORT) || (state == ST_HOLD))
		else $error("start code wrong");
	a_addr_code: assert property (seq_addr_ack |=> pend_code == CODE_SLAW_ACK)
		else $error("address ack code wrong");
	a_lost_code: assert property ((state == ST_BIT) && adv && (ph == PH_SAMPLE)
		&& shifter[7] && !sda_s |=> pend_code == CODE_ARB_LOST && !sda_oe)
		else $error("arbitration loss not reported");
	a_mask_zero: assert property (flag |-> (bus_state_reg & ~CODE_MASK) == 8'h00)
		else $error("prescaler bits set in status");
endmodule // twm_master_tx

// ===== tb/twm_slave_model.sv
// behavioural slave receiver, plus a rival master that can hold the data line low
// assumes pulled-up open-drain lines and the same clk_i as the block
`timescale 1ns/1ps

module twm_slave_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic       ack_i,
	input  wire logic       arb_i,
	input  wire logic [3:0] stretch_i,
	output logic            scl_oe_o,
	output logic            sda_oe_o,
	output logic [7:0]      rx_byte_o
);
	logic       scl_q;
	logic       sda_q;
	logic       active;
	logic       ack_drv;
	logic       arb_hold;
	logic [3:0] cnt;
	logic [3:0] st_cnt;
	logic [7:0] sh;

	// ----------------------------------------
	// bus watcher
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			{scl_q, sda_q} <= 2'b11;
			{active, ack_drv, arb_hold} <= 3'b000;
			cnt <= 4'h0;
			st_cnt <= 4'h0;
			sh <= 8'h00;
			rx_byte_o <= 8'h00;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
			// rival grabs data only while clock is low, so no false start
			if (arb_i && !scl_i)
				arb_hold <= 1'b1;
			else if (!arb_i)
				arb_hold <= 1'b0;
			if (st_cnt != 4'h0)
				st_cnt <= st_cnt - 4'h1;
			if (scl_q && scl_i && sda_q && !sda_i) begin
				active <= 1'b1;
				cnt <= 4'h0;
				ack_drv <= 1'b0;
			end else if (scl_q && scl_i && !sda_q && sda_i) begin
				active <= 1'b0;
				ack_drv <= 1'b0;
			end else if (active && !scl_q && scl_i) begin
				if (cnt < 4'h8)
					sh <= {sh[6:0], sda_i};
				cnt <= cnt + 4'h1;
			end else if (active && scl_q && !scl_i) begin
				st_cnt <= stretch_i;
				if (cnt == 4'h8) begin
					ack_drv <= ack_i;
					rx_byte_o <= sh;
				end else if (cnt == 4'h9) begin
					ack_drv <= 1'b0;
					cnt <= 4'h0;
				end
			end
		end
	end

	assign scl_oe_o = (st_cnt != 4'h0);
	assign sda_oe_o = ack_drv | arb_hold;
endmodule // twm_slave_model

// ===== tb/twm_master_tx_bench.sv
// self-checking bench for the two-wire master send engine
// assumes the slave model in tb/ and pull-ups on both lines
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end

module twm_master_tx_bench;
	import twm_pkg::*;
	logic       clk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic       ctl_wr = 1'b0;
	twm_ctl_t   ctl = '0;
	logic       data_wr = 1'b0;
	logic [7:0] data = 8'h00;
	logic       evt_ready = 1'b0;
	logic       ack = 1'b1;
	logic       arb = 1'b0;
	logic [3:0] stretch = 4'h0;
	logic       flag_o, write_collision_flag_o, start_request_o, stop_request_o;
	logic       enable_o, master_receive_mode_o, bus_busy_o, evt_valid_o;
	logic [7:0] bus_state_reg_o, shift_data_reg_o, evt_code_o, rx_byte, b, adr;
	logic       scl_oe_o, sda_oe_o, p_scl_oe, p_sda_oe, scl_w, sda_w, scl_lvl, sda_lvl;
	logic [7:0] exp_q[$];
	int         n_mismatch = 0;
	int         checked = 0;
	int         i;

	always #50 clk_i = ~clk_i;
	assign scl_w = !(scl_oe_o | p_scl_oe);
	assign sda_w = !(sda_oe_o | p_sda_oe);

	twm_master_tx dut (.clk_i(clk_i), .rst_i(rst_i), .ctl_wr_i(ctl_wr), .ctl_i(ctl),
		.data_wr_i(data_wr), .data_i(data), .flag_o(flag_o),
		.write_collision_flag_o(write_collision_flag_o), .start_request_o(start_request_o),
		.stop_request_o(stop_request_o), .enable_o(enable_o),
		.bus_state_reg_o(bus_state_reg_o), .shift_data_reg_o(shift_data_reg_o),
		.master_receive_mode_o(master_receive_mode_o), .bus_busy_o(bus_busy_o),
		.evt_valid_o(evt_valid_o), .evt_ready_i(evt_ready), .evt_code_o(evt_code_o),
		.scl_i(scl_w), .scl_o(scl_lvl), .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_lvl),
		.sda_oe_o(sda_oe_o));

	twm_slave_model partner (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_w), .sda_i(sda_w),
		.ack_i(ack), .arb_i(arb), .stretch_i(stretch), .scl_oe_o(p_scl_oe),
		.sda_oe_o(p_sda_oe), .rx_byte_o(rx_byte));

	// ----------------------------------------
	// software-side tasks
	// ----------------------------------------
	task automatic ctl_write(input logic e, s, p, c);
		@(posedge clk_i);
		ctl_wr <= 1'b1;
		ctl <= '{e, s, p, c};
		@(posedge clk_i);
		ctl_wr <= 1'b0;
	endtask

	task automatic data_write(input logic [7:0] v);
		@(posedge clk_i);
		data_wr <= 1'b1;
		data <= v;
		@(posedge clk_i);
		data_wr <= 1'b0;
	endtask

	// rest: whether a stalled code is expected to remain in the buffer
	task automatic drain(input logic rest);
		logic [7:0] e;
		for (int k = 0; k < 500 && exp_q.size() > 0; k++) begin
			@(posedge clk_i);
			evt_ready <= 1'($urandom % 2);
			@(negedge clk_i);
			if (evt_ready && evt_valid_o) begin
				e = exp_q.pop_front();
				`CHK(evt_code_o, e)
			end
		end
		@(posedge clk_i);
		evt_ready <= 1'b0;
		@(negedge clk_i);
		`CHK(evt_valid_o, rest)
	endtask

	// full buffer must stall the flag until a slot frees
	task automatic wait_flag(input logic [7:0] code);
		if (exp_q.size() == 8) begin
			repeat (400) @(negedge clk_i);
			`CHK(flag_o, 1'b0)
			drain(1'b1);
		end
		@(negedge clk_i);
		for (i = 0; flag_o !== 1'b1 && i < 3000; i++)
			@(negedge clk_i);
		`CHK(flag_o, 1'b1)
		`CHK(bus_state_reg_o & CODE_MASK, code)
		`CHK(bus_state_reg_o[1:0], 2'h0)
		exp_q.push_back(code);
	endtask

	task automatic send_stop();
		ctl_write(1'b1, 1'b0, 1'b1, 1'b1);
		@(negedge clk_i);
		`CHK(stop_request_o, 1'b1)
		for (i = 0; stop_request_o !== 1'b0 && i < 500; i++)
			@(negedge clk_i);
		`CHK(stop_request_o, 1'b0)
		repeat (4) @(negedge clk_i);
		`CHK({bus_busy_o, scl_oe_o, sda_oe_o, flag_o}, 4'h0)
	endtask

	task automatic report_and_stop();
		$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		#3000000;
		n_mismatch++;
		report_and_stop();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h942a2acf));
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		`CHK({flag_o, evt_valid_o, scl_oe_o, sda_oe_o, scl_lvl, sda_lvl}, 6'h00)
		`CHK({bus_state_reg_o, shift_data_reg_o}, {CODE_NONE, DATA_RESET})
		adr = {7'($urandom | 32'h1), 1'b0};
		ctl_write(1'b1, 1'b1, 1'b0, 1'b1);
		data_write(8'h55);
		@(negedge clk_i);
		`CHK({write_collision_flag_o, shift_data_reg_o}, {1'b1, DATA_RESET})
		`CHK({enable_o, start_request_o}, 2'b11)
		wait_flag(CODE_START);
		ctl_write(1'b1, 1'b1, 1'b0, 1'b0);
		repeat (20) @(negedge clk_i);
		`CHK({flag_o, bus_state_reg_o}, {1'b1, CODE_START})
		`CHK(scl_oe_o, 1'b1)
		data_write(adr);
		@(negedge clk_i);
		`CHK({write_collision_flag_o, shift_data_reg_o}, {1'b0, adr})
		ctl_write(1'b1, 1'b0, 1'b0, 1'b1);
		wait_flag(CODE_SLAW_ACK);
		`CHK(master_receive_mode_o, 1'b0)
		repeat (3) begin
			b = 8'($urandom);
			ack <= 1'($urandom % 2);
			stretch <= 4'($urandom);
			data_write(b);
			ctl_write(1'b1, 1'b0, 1'b0, 1'b1);
			wait_flag(ack ? CODE_DATA_ACK : CODE_DATA_NACK);
			`CHK(rx_byte, b)
		end
		ack <= 1'b1;
		ctl_write(1'b1, 1'b1, 1'b0, 1'b1);
		wait_flag(CODE_REP_START);
		data_write(adr | 8'h01);
		ctl_write(1'b1, 1'b0, 1'b0, 1'b1);
		wait_flag(CODE_SLAR_ACK);
		`CHK({master_receive_mode_o, rx_byte}, {1'b1, adr | 8'h01})
		ctl_write(1'b1, 1'b1, 1'b1, 1'b1);
		wait_flag(CODE_START);
		ack <= 1'b0;
		data_write(adr);
		ctl_write(1'b1, 1'b0, 1'b0, 1'b1);
		wait_flag(CODE_SLAW_NACK);
		send_stop();
		arb <= 1'b1;
		ctl_write(1'b1, 1'b1, 1'b0, 1'b1);
		wait_flag(CODE_START);
		data_write(8'ha4);
		ctl_write(1'b1, 1'b0, 1'b0, 1'b1);
		wait_flag(CODE_ARB_LOST);
		`CHK({scl_oe_o, sda_oe_o}, 2'b00)
		ctl_write(1'b1, 1'b0, 1'b0, 1'b1);
		repeat (50) @(negedge clk_i);
		`CHK({flag_o, scl_oe_o, sda_oe_o}, 3'h0)
		ctl_write(1'b1, 1'b1, 1'b0, 1'b1);
		repeat (50) @(negedge clk_i);
		`CHK({flag_o, scl_oe_o, sda_oe_o}, 3'h0)
		arb <= 1'b0;
		wait_flag(CODE_START);
		send_stop();
		drain(1'b0);
		report_and_stop();
	end
endmodule // twm_master_tx_bench
